// >>> core/pcic_pkg.sv
// Purpose: Shared types and constants for the pipeline cycle and interlock control.
// Assumes: All instruction and data accesses hit in the caches.
// Notes:   Cycle counts are in core clock cycles, 25 MHz core clock.
`default_nettype none
package pcic_pkg;
    localparam int CNT_W  = 9;
    localparam int REGS   = 16;
    localparam int BW_W   = 8;
    // Cycle counts of the fixed-length instruction classes.
    localparam logic [CNT_W-1:0] CYC_ONE         = 9'h001;
    localparam logic [CNT_W-1:0] CYC_REGSHIFT    = 9'h002;
    localparam logic [CNT_W-1:0] CYC_LOAD_USE    = 9'h002;
    localparam logic [CNT_W-1:0] CYC_LOAD_NARROW = 9'h003;
    localparam logic [CNT_W-1:0] CYC_LOAD_PC     = 9'h005;
    localparam logic [CNT_W-1:0] CYC_BLK_ONE     = 9'h002;
    localparam logic [CNT_W-1:0] CYC_PC_EXTRA    = 9'h004;
    localparam logic [CNT_W-1:0] CYC_SWAP        = 9'h002;
    localparam logic [CNT_W-1:0] CYC_SWAP_USE    = 9'h003;
    localparam logic [CNT_W-1:0] CYC_BRANCH      = 9'h003;
    localparam logic [CNT_W-1:0] CYC_MUL_BASE    = 9'h002;
    localparam logic [CNT_W-1:0] CYC_MULL_BASE   = 9'h003;
    // Positions inside a loaded-pc sequence and the multiplier operand fields.
    localparam logic [CNT_W-1:0] LDPC_SEQ2_K     = 9'h003;
    localparam logic [CNT_W-1:0] LDPC_NSEQ_K     = 9'h004;
    localparam logic [3:0]       PC_IDX          = 4'hF;
    localparam int MSEL_HI   = 11;
    localparam int MSEL_LO   = 8;
    localparam int MSEL_C_HI = 2;
    localparam int ET_B1     = 8;
    localparam int ET_B2     = 16;
    localparam int ET_B3     = 24;
    localparam logic [2:0] M_MAX = 3'h4;

    typedef enum logic [3:0] {
        CL_DATA_OP = 4'h0, CL_SINGLE_LOAD = 4'h1, CL_SINGLE_STORE = 4'h2,
        CL_BLOCK_LOAD = 4'h3, CL_BLOCK_STORE = 4'h4, CL_ATOMIC_SWAP = 4'h5,
        CL_COPROC_DATA_OP = 4'h6, CL_COPROC_LOAD = 4'h7, CL_COPROC_STORE = 4'h8,
        CL_COPROC_REG_WRITE = 4'h9, CL_COPROC_REG_READ = 4'hA,
        CL_SHORT_MULTIPLY = 4'hB, CL_MULTIPLY_ACCUMULATE = 4'hC,
        CL_UNSIGNED_LONG_MULTIPLY = 4'hD, CL_SIGNED_LONG_MULTIPLY = 4'hE,
        CL_BRANCH = 4'hF
    } pcic_class_t;

    typedef enum logic [1:0] {
        BUS_S = 2'h0, BUS_N = 2'h1, BUS_I = 2'h2, BUS_C = 2'h3
    } pcic_bus_t;

    typedef struct packed {
        pcic_class_t      opClass;
        logic             regShift;
        logic             useNext;
        logic             narrow;
        logic             destPc;
        logic [REGS-1:0]  regList;
        logic [REGS-1:0]  nextSrc;
        logic [BW_W-1:0]  busyWait;
        logic [31:0]      instrWord;
        logic             compressed;
        logic [31:0]      mulOp;
    } pcic_instr_t;

    typedef struct packed {
        pcic_bus_t  iType;
        pcic_bus_t  dType;
        logic       fetchReq;
        logic       interlock;
        logic       xferValid;
        logic [3:0] xferReg;
    } pcic_cycle_t;
endpackage
`default_nettype wire

// >>> core/pcic_control.sv
// Purpose: Sequences each instruction class through its core cycles and bus activity.
// Assumes: Cache hits only; operand values and register lists arrive with the instruction.
// Notes:   Every per-cycle output except the combinational issueReady is registered and shows cycle k of the current instruction.
`default_nettype none
// Function
// - Register-shifted data op: two cycles, S then I.
// - Load word used next: two cycles.
// - Narrow or unaligned load used next: three cycles.
// - Load to pc: five cycles, 2S 2I 1N.
// - Block load one register: two cycles.
// - Block load n registers: n cycles, N then S.
// - Block load with pc: n+4 cycles.
// - Block store: two cycles single, else n.
// - Swap: two cycles, three if byte used.
// - Coprocessor read: b+2 if used, else b+1.
// - Multiply 2+m, long multiply 3+m cycles.
// - Operand register from bits 11:8 or 2:0.
// - Signed and short: sign-run early termination.
// - Unsigned long: zero-run early termination only.
// - Interlock stops instruction fetches.
// - Block load transfers registers lowest first.
// - Dependent held until final block transfer.
// - Last-register dependency adds one interlock cycle.
// - Data side bursts: one N then S.
module pcic_control
    import pcic_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              resetn,
    // Instruction issue handshake.
    input  wire logic              issueValid,
    input  wire pcic_instr_t       issueInstr,
    output logic                   issueReady,
    // Per-cycle bus activity.
    output pcic_cycle_t            cycleOut,
    output logic                   busy,
    output logic                   lastCycle,
    output logic [CNT_W-1:0]       instrCycles,
    // Dependency and multiplier status.
    output logic                   holdDependent,
    output logic [3:0]             mulSel,
    output logic [2:0]             mulTerm
);

    function automatic logic [4:0] popCount(input logic [REGS-1:0] m);
        logic [4:0] c;
        c = 5'h00;
        for (int i = 0; i < REGS; i++) begin
            c = c + {4'h0, m[i]};
        end
        return c;
    endfunction

    function automatic logic [3:0] lowBit(input logic [REGS-1:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = REGS - 1; i >= 0; i--) begin
            if (m[i]) r = 4'(i);
        end
        return r;
    endfunction

    function automatic logic [3:0] highBit(input logic [REGS-1:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < REGS; i++) begin
            if (m[i]) r = 4'(i);
        end
        return r;
    endfunction

    // Early termination: the signed test accepts a run of ones as well as zeros.
    function automatic logic [2:0] earlyTerm(input logic [31:0] op, input logic unsLong);
        logic [2:0] m;
        m = M_MAX;
        if ((~|op[31:ET_B3]) || (!unsLong && (&op[31:ET_B3]))) m = 3'h3;
        if ((~|op[31:ET_B2]) || (!unsLong && (&op[31:ET_B2]))) m = 3'h2;
        if ((~|op[31:ET_B1]) || (!unsLong && (&op[31:ET_B1]))) m = 3'h1;
        return m;
    endfunction

    // The extra cycle only applies when the pc is not among the loaded registers.
    function automatic logic depLastOf(input pcic_instr_t d);
        return (d.opClass == CL_BLOCK_LOAD) && !d.regList[PC_IDX]
            && (popCount(d.regList) > 5'h01) && d.nextSrc[highBit(d.regList)];
    endfunction

    function automatic logic [CNT_W-1:0] totalOf(input pcic_instr_t d);
        logic [CNT_W-1:0] n;
        logic [CNT_W-1:0] b;
        logic [CNT_W-1:0] m;
        logic [CNT_W-1:0] t;
        n = CNT_W'(popCount(d.regList));
        b = CNT_W'(d.busyWait);
        m = CNT_W'(earlyTerm(d.mulOp, d.opClass == CL_UNSIGNED_LONG_MULTIPLY));
        t = CYC_ONE;
        case (d.opClass)
            CL_DATA_OP:        t = d.regShift ? CYC_REGSHIFT : CYC_ONE;
            CL_SINGLE_LOAD: begin
                if (d.destPc) begin
                    t = CYC_LOAD_PC;
                end else if (d.useNext) begin
                    t = d.narrow ? CYC_LOAD_NARROW : CYC_LOAD_USE;
                end
            end
            CL_BLOCK_LOAD: begin
                if (d.regList[PC_IDX]) begin
                    t = n + CYC_PC_EXTRA;
                end else if (n == CYC_ONE) begin
                    t = CYC_BLK_ONE;
                end else begin
                    t = n + CNT_W'(depLastOf(d));
                end
            end
            CL_BLOCK_STORE:    t = (n == CYC_ONE) ? CYC_BLK_ONE : n;
            CL_ATOMIC_SWAP:    t = (d.useNext && d.narrow) ? CYC_SWAP_USE : CYC_SWAP;
            CL_COPROC_DATA_OP, CL_COPROC_REG_WRITE: t = b + CYC_ONE;
            CL_COPROC_LOAD, CL_COPROC_STORE:        t = b + n;
            CL_COPROC_REG_READ: t = b + CYC_ONE + CNT_W'(d.useNext);
            CL_SHORT_MULTIPLY, CL_MULTIPLY_ACCUMULATE: t = CYC_MUL_BASE + m;
            CL_UNSIGNED_LONG_MULTIPLY, CL_SIGNED_LONG_MULTIPLY: t = CYC_MULL_BASE + m;
            CL_BRANCH:         t = CYC_BRANCH;
            default:           t = CYC_ONE;
        endcase
        return t;
    endfunction

    // Bus activity of cycle k; stalled cycles never request the instruction side.
    function automatic pcic_cycle_t cycleOf(input pcic_instr_t d, input logic [CNT_W-1:0] k,
                                            input logic [CNT_W-1:0] t);
        pcic_cycle_t      c;
        logic [CNT_W-1:0] n;
        logic [CNT_W-1:0] b;
        n = CNT_W'(popCount(d.regList));
        b = CNT_W'(d.busyWait);
        c = '0;
        c.iType = (k == '0) ? BUS_S : BUS_I;
        c.dType = BUS_I;
        case (d.opClass)
            CL_SINGLE_LOAD: begin
                c.dType = (k == '0) ? BUS_N : BUS_I;
                if (d.destPc) begin
                    if (k == LDPC_SEQ2_K) c.iType = BUS_S;
                    if (k == LDPC_NSEQ_K) c.iType = BUS_N;
                end else begin
                    c.interlock = (k != '0);
                end
            end
            CL_SINGLE_STORE: c.dType = BUS_N;
            CL_BLOCK_LOAD, CL_BLOCK_STORE: begin
                if (k < n) begin
                    c.dType = (k == '0) ? BUS_N : BUS_S;
                    c.xferValid = 1'b1;
                end
                if (d.opClass == CL_BLOCK_LOAD && !d.regList[PC_IDX] && n == CYC_ONE) begin
                    c.dType = (k == '0) ? BUS_S : BUS_I;
                end
                if (d.opClass == CL_BLOCK_LOAD && d.regList[PC_IDX]) begin
                    if (k == n + CYC_LOAD_USE) c.iType = BUS_S;
                    if (k == n + CYC_LOAD_NARROW) c.iType = BUS_N;
                end
                c.interlock = depLastOf(d) && (k == t - CYC_ONE);
            end
            CL_ATOMIC_SWAP: begin
                c.dType = (k < CYC_SWAP) ? BUS_N : BUS_I;
                c.interlock = (k == CYC_SWAP);
            end
            CL_COPROC_LOAD, CL_COPROC_STORE: begin
                if (k == b) c.dType = BUS_N;
                if (k > b) c.dType = BUS_S;
            end
            CL_COPROC_REG_WRITE, CL_COPROC_REG_READ: begin
                c.dType = (k == t - CYC_ONE) ? BUS_C : BUS_I;
                c.interlock = (d.opClass == CL_COPROC_REG_READ) && d.useNext
                    && (k == t - CYC_ONE);
            end
            CL_BRANCH: c.iType = (k < CYC_LOAD_USE) ? BUS_S : BUS_N;
            default: c.dType = BUS_I;
        endcase
        if (c.interlock) c.iType = BUS_I;
        c.fetchReq = (c.iType != BUS_I);
        return c;
    endfunction

    pcic_instr_t       desc_reg;
    pcic_instr_t       desc_next;
    logic [CNT_W-1:0]  k_reg;
    logic [CNT_W-1:0]  k_next;
    logic [CNT_W-1:0]  total_reg;
    logic [CNT_W-1:0]  total_next;
    logic              busy_reg;
    logic              busy_next;
    logic [REGS-1:0]   rem_reg;
    logic [REGS-1:0]   rem_next;
    logic              lastNow;
    logic              accept;
    pcic_cycle_t       cyc_next;
    logic              hold_next;

    // A new instruction may enter in the last cycle of the current one.
    assign lastNow    = busy_reg && (k_reg == total_reg - CYC_ONE);
    assign issueReady = !busy_reg || lastNow;
    assign accept     = issueValid && issueReady;

    // Next-state selection; the remaining mask drops its lowest bit per transfer.
    always_comb begin
        desc_next  = desc_reg;
        k_next     = k_reg;
        total_next = total_reg;
        busy_next  = busy_reg;
        rem_next   = rem_reg;
        if (accept) begin
            desc_next  = issueInstr;
            k_next     = '0;
            total_next = totalOf(issueInstr);
            busy_next  = 1'b1;
            rem_next   = issueInstr.regList;
        end else if (lastNow) begin
            busy_next  = 1'b0;
        end else if (busy_reg) begin
            k_next     = k_reg + CYC_ONE;
            if (cycleOut.xferValid) begin
                rem_next = rem_reg & (rem_reg - 16'h0001);
            end
        end
    end

    // Output values for the cycle that the next edge begins.
    always_comb begin
        cyc_next = cycleOf(desc_next, k_next, total_next);
        cyc_next.xferReg = lowBit(rem_next);
        if (!busy_next) begin
            cyc_next = '0;
            cyc_next.iType = BUS_I;
            cyc_next.dType = BUS_I;
        end
        // Held before the final transfer, one more cycle for the last register.
        hold_next = busy_next && (desc_next.opClass == CL_BLOCK_LOAD)
            && (|(desc_next.regList & desc_next.nextSrc)) && !desc_next.regList[PC_IDX]
            && (k_next + CYC_ONE < CNT_W'(popCount(desc_next.regList))
                + CNT_W'(depLastOf(desc_next)));
    end

    // Sequencer state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            desc_reg  <= '0;
            k_reg     <= '0;
            total_reg <= CYC_ONE;
            busy_reg  <= 1'b0;
            rem_reg   <= '0;
        end else begin
            desc_reg  <= desc_next;
            k_reg     <= k_next;
            total_reg <= total_next;
            busy_reg  <= busy_next;
            rem_reg   <= rem_next;
        end
    end

    // Registered outputs, aligned with the sequencer state.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cycleOut      <= '{iType: BUS_I, dType: BUS_I, default: '0};
            busy          <= 1'b0;
            lastCycle     <= 1'b0;
            instrCycles   <= '0;
            holdDependent <= 1'b0;
        end else begin
            cycleOut      <= cyc_next;
            busy          <= busy_next;
            lastCycle     <= busy_next && (k_next == total_next - CYC_ONE);
            instrCycles   <= busy_next ? total_next : '0;
            holdDependent <= hold_next;
        end
    end

    // Multiplier operand selector and term, captured when an instruction enters.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mulSel  <= 4'h0;
            mulTerm <= 3'h0;
        end else if (accept) begin
            mulSel  <= issueInstr.compressed ? {1'b0, issueInstr.instrWord[MSEL_C_HI:0]}
                                             : issueInstr.instrWord[MSEL_HI:MSEL_LO];
            mulTerm <= earlyTerm(issueInstr.mulOp,
                                 issueInstr.opClass == CL_UNSIGNED_LONG_MULTIPLY);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_regshift_two: assert property (
        accept && issueInstr.opClass == CL_DATA_OP && issueInstr.regShift |=>
        (cycleOut.iType == BUS_S && !lastCycle) ##1 (cycleOut.iType == BUS_I && lastCycle))
        else $error("register shift data op not two cycles");
    a_load_use: assert property (
        accept && issueInstr.opClass == CL_SINGLE_LOAD && issueInstr.useNext
        && !issueInstr.narrow && !issueInstr.destPc |=>
        cycleOut.dType == BUS_N ##1 (cycleOut.interlock && lastCycle))
        else $error("load-use stall wrong");
    a_load_narrow: assert property (
        accept && issueInstr.opClass == CL_SINGLE_LOAD && issueInstr.useNext
        && issueInstr.narrow && !issueInstr.destPc |=>
        !lastCycle ##1 cycleOut.interlock[*2] ##0 lastCycle)
        else $error("narrow load stall wrong");
    a_load_pc: assert property (
        accept && issueInstr.opClass == CL_SINGLE_LOAD && issueInstr.destPc |=>
        cycleOut.iType == BUS_S ##1 cycleOut.iType == BUS_I ##1 cycleOut.iType == BUS_I
        ##1 cycleOut.iType == BUS_S ##1 (cycleOut.iType == BUS_N && lastCycle))
        else $error("pc load sequence wrong");
    a_swap_seq: assert property (
        accept && issueInstr.opClass == CL_ATOMIC_SWAP && !issueInstr.useNext |=>
        cycleOut.dType == BUS_N ##1 (cycleOut.dType == BUS_N && lastCycle))
        else $error("swap sequence wrong");
    a_mul_short: assert property (
        accept && issueInstr.opClass == CL_SHORT_MULTIPLY
        && issueInstr.mulOp[31:ET_B1] == '0 |=> !lastCycle ##1 !lastCycle ##1 lastCycle)
        else $error("short multiply not three cycles");
    a_mul_signed: assert property (
        accept && issueInstr.opClass == CL_SIGNED_LONG_MULTIPLY
        && (&issueInstr.mulOp[31:ET_B2]) && !issueInstr.mulOp[ET_B1+7] |=> mulTerm == 3'h2)
        else $error("signed early termination wrong");
    a_mul_unsigned: assert property (
        accept && issueInstr.opClass == CL_UNSIGNED_LONG_MULTIPLY
        && issueInstr.mulOp[31] |=> mulTerm == M_MAX && instrCycles == 9'h007)
        else $error("unsigned early termination wrong");
    a_stall_nofetch: assert property (
        cycleOut.interlock |-> !cycleOut.fetchReq && cycleOut.iType == BUS_I)
        else $error("fetch during interlock");
    a_xfer_ascend: assert property (
        cycleOut.xferValid && $past(cycleOut.xferValid) && !$past(lastCycle) |->
        cycleOut.xferReg > $past(cycleOut.xferReg))
        else $error("block transfer order not ascending");

endmodule
`default_nettype wire

// >>> test/pcic_mem_model.sv
// Purpose: Cache model at the far side of the cycle control.
// Assumes: Every access hits, so no wait state is ever given.
// Notes:   Tallies accesses so the bench can match bus activity per instruction.
`default_nettype none
module pcic_mem_model
    import pcic_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Bus activity seen.
    input  wire pcic_cycle_t cycleIn,
    // Access tallies.
    output logic [15:0]      fetchCnt,
    output logic [15:0]      dataNCnt,
    output logic [15:0]      dataSCnt,
    output logic [15:0]      badCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic isFetch;

    // Only S and N cycles reach the cache; an I cycle must not request.
    assign isFetch = (cycleIn.iType == BUS_S) || (cycleIn.iType == BUS_N);

    // Hits answer at once, so counting accesses is all this cache does.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetchCnt <= 16'h0000;
            dataNCnt <= 16'h0000;
            dataSCnt <= 16'h0000;
            badCnt   <= 16'h0000;
        end else begin
            fetchCnt <= fetchCnt + 16'(cycleIn.fetchReq);
            dataNCnt <= dataNCnt + 16'(cycleIn.dType == BUS_N);
            dataSCnt <= dataSCnt + 16'(cycleIn.dType == BUS_S);
            badCnt   <= badCnt + 16'(cycleIn.fetchReq != isFetch);
        end
    end
endmodule
`default_nettype wire

// >>> test/pipeline_cycle_interlock_control_bench.sv
// Purpose: Self-checking bench for the pipeline cycle and interlock control.
// Assumes: The cache model always hits; one instruction is offered at a time.
// Notes:   Expected counts come from an integer reference model in this file.
`default_nettype none
module pipeline_cycle_interlock_control_bench import pcic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clk = 1'b0;
    logic             resetn = 1'b0;
    logic             issueValid = 1'b0;
    pcic_instr_t      issueInstr = '0;
    logic             issueReady, busy, lastCycle, holdDependent;
    pcic_cycle_t      cycleOut;
    logic [CNT_W-1:0] instrCycles;
    logic [3:0]       mulSel;
    logic [2:0]       mulTerm;
    logic [15:0]      fetchCnt, dataNCnt, dataSCnt, badCnt;
    logic [31:0]      seed = 32'h54ec_c459;
    int               error_cnt = 0;
    int               checks = 0;

    pcic_control dut_u (.clk(clk), .resetn(resetn), .issueValid(issueValid),
        .issueInstr(issueInstr), .issueReady(issueReady), .cycleOut(cycleOut), .busy(busy),
        .lastCycle(lastCycle), .instrCycles(instrCycles), .holdDependent(holdDependent),
        .mulSel(mulSel), .mulTerm(mulTerm));
    pcic_mem_model mem_u (.clk(clk), .resetn(resetn), .cycleIn(cycleOut),
        .fetchCnt(fetchCnt), .dataNCnt(dataNCnt), .dataSCnt(dataSCnt), .badCnt(badCnt));

    // Free-running core clock, 40 ns period.
    initial begin
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Reference early-termination count; unsigned forms accept only zero runs.
    function automatic int mterm(logic [31:0] v, bit uns);
        for (int j = 1; j < 4; j++) begin
            if ((v >> (8 * j)) == 0 || (!uns && ((~v) >> (8 * j)) == 0)) return j;
        end
        return 4;
    endfunction

    function automatic pcic_instr_t mk(pcic_class_t c);
        pcic_instr_t d;
        d = '0;
        d.opClass = c;
        return d;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Issues one instruction from idle and follows it to its last cycle.
    // A negative expectation means the figure is not fixed for that case.
    task automatic run(input pcic_instr_t d, input int cyc, fet, dn, ds, il, hd);
        int k;
        int nIl;
        int nHd;
        int nx;
        logic [15:0] f0, n0, s0, b0, rl;
        nIl = 0;
        nHd = 0;
        rl = d.regList;
        f0 = fetchCnt;
        n0 = dataNCnt;
        s0 = dataSCnt;
        b0 = badCnt;
        @(posedge clk);
        issueValid <= 1'b1;
        issueInstr <= d;
        @(posedge clk);
        issueValid <= 1'b0;
        for (k = 1; k < 600; k++) begin
            #1;
            if (k == 1) chk(32'(instrCycles), cyc);
            chk({busy, issueReady}, {1'b1, k == cyc});
            if (cycleOut.interlock === 1'b1) nIl++;
            if (holdDependent === 1'b1) nHd++;
            if (d.opClass == CL_BLOCK_LOAD && cycleOut.xferValid === 1'b1) begin
                nx = 0;
                while (nx < 15 && !rl[nx]) nx++;
                chk(32'(cycleOut.xferReg), nx);
                rl[nx] = 1'b0;
            end
            if (lastCycle === 1'b1) break;
            @(posedge clk);
        end
        chk(k, cyc);
        @(posedge clk);
        #1;
        chk({busy, issueReady}, 2'b01);
        chk(badCnt - b0, 0);
        if (fet >= 0) chk(fetchCnt - f0, fet);
        if (dn >= 0) chk(dataNCnt - n0, dn);
        if (ds >= 0) chk(dataSCnt - s0, ds);
        if (il >= 0) chk(nIl, il);
        if (hd >= 0) chk(nHd, hd);
        if (d.opClass == CL_BLOCK_LOAD) chk(rl, 0);
    endtask

    // Main sequence: one group of instruction classes after another.
    initial begin
        pcic_instr_t d;
        logic [31:0] r;
        int i, j, n, hi, lst, b, m;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 2; i++) begin
            d = mk(CL_DATA_OP);
            d.regShift = i[0];
            run(d, 1 + i, 1, 0, 0, -1, -1);
        end
        for (i = 0; i < 4; i++) begin
            d = mk(CL_SINGLE_LOAD);
            d.useNext = (i == 1 || i == 2);
            d.narrow = (i == 2);
            d.destPc = (i == 3);
            n = (i == 3) ? 5 : 1 + i;
            run(d, n, (i == 3) ? 3 : 1, 1, 0, (i == 3) ? -1 : i, -1);
        end
        d = mk(CL_SINGLE_STORE);
        run(d, 1, 1, 1, 0, -1, -1);
        $display("Test single ops done, %0d checks", checks);
        // Block loads: single registers first, then random lists with and without pc.
        for (i = 0; i < 24; i++) begin
            d = mk(CL_BLOCK_LOAD);
            r = rnd();
            d.regList = (i < 3) ? 16'(1 << (5 * i)) : (r[15:0] | 16'h0002);
            d.nextSrc = (i < 3) ? d.regList : (r[31:16] & 16'(rnd()));
            d.destPc = d.regList[PC_IDX];
            n = $countones(d.regList);
            hi = 0;
            for (j = 0; j < 16; j++) if (d.regList[j]) hi = j;
            lst = (n > 1 && d.nextSrc[hi]) ? 1 : 0;
            if (d.destPc) run(d, n + 4, 3, 1, n - 1, -1, -1);
            else if (n == 1) run(d, 2, 1, 0, 1, -1, 0);
            else run(d, n + lst, 1, 1, n - 1, -1, |(d.regList & d.nextSrc) ? n - 1 + lst : 0);
        end
        for (i = 0; i < 6; i++) begin
            d = mk(CL_BLOCK_STORE);
            d.regList = (i == 0) ? 16'h0001 : (16'(rnd()) | 16'h0001);
            n = $countones(d.regList);
            run(d, (n == 1) ? 2 : n, 1, 1, n - 1, -1, -1);
        end
        $display("Test block ops done, %0d checks", checks);
        for (i = 0; i < 2; i++) begin
            d = mk(CL_ATOMIC_SWAP);
            d.useNext = i[0];
            d.narrow = i[0];
            run(d, 2 + i, 1, 2, 0, i, -1);
        end
        for (i = 0; i < 6; i++) begin
            d = mk(CL_COPROC_REG_READ);
            b = rnd() % 6;
            d.busyWait = 8'(b);
            d.useNext = i[0];
            run(d, b + 1 + i % 2, 1, -1, -1, -1, -1);
        end
        // Remaining coprocessor forms and a branch; only loads and stores burst on data.
        for (i = 0; i < 5; i++) begin
            d = mk((i == 4) ? CL_BRANCH : pcic_class_t'(4'h6 + 4'(i)));
            b = rnd() % 4;
            d.busyWait = 8'(b);
            d.regList = 16'(rnd()) | 16'h0100;
            n = (i == 1 || i == 2) ? $countones(d.regList) : 0;
            hi = (i == 4) ? 3 : b + ((n > 0) ? n : 1);
            lst = (n > 0) ? 1 : 0;
            run(d, hi, (i == 4) ? 3 : 1, lst, n - lst, 0, -1);
        end
        $display("Test swap and coprocessor done, %0d checks", checks);
        // Multiplies with operands shaped to hit every early-termination step.
        for (i = 0; i < 32; i++) begin
            d = mk(pcic_class_t'(4'hB + 4'(i % 4)));
            r = rnd() >> (8 * (rnd() % 4));
            d.mulOp = (rnd() % 2 == 1) ? ~r : r;
            // The first pass forces each asserted early-termination case.
            if (i == 0) d.mulOp = {24'h00_0000, r[7:0]};
            if (i == 2) d.mulOp = {1'b1, r[30:0]};
            if (i == 3) d.mulOp = {16'hFFFF, 1'b0, r[14:0]};
            d.instrWord = rnd();
            d.compressed = i[2];
            m = mterm(d.mulOp, d.opClass == CL_UNSIGNED_LONG_MULTIPLY);
            n = (d.opClass >= CL_UNSIGNED_LONG_MULTIPLY) ? 3 : 2;
            run(d, n + m, 1, 0, 0, -1, -1);
            chk(mulTerm, m);
            chk(mulSel, d.compressed ? {1'b0, d.instrWord[2:0]} : d.instrWord[11:8]);
        end
        $display("Test multiplies done, %0d checks", checks);
        final_report();
    end

    // Watchdog: the tests need well under a tenth of this span.
    initial begin
        #(40 * 30000);
        error_cnt++;
        final_report();
    end
endmodule
`default_nettype wire
